// ### ocf_pkg.sv
package ocf_pkg;
    // command codes of the channel's fault response bytes and of clear-faults
    localparam logic [7:0] CMD_OC_RESPONSE = 8'h47;
    localparam logic [7:0] CMD_INT_OT_RESPONSE = 8'hD6;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    // reset and fixed values
    localparam logic [7:0] OC_RESPONSE_RESET = 8'h00;
    localparam logic [7:0] INT_OT_RESPONSE_VALUE = 8'hC0;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    // field positions of the response byte
    localparam int RESP_MSB = 7;
    localparam int RESP_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    typedef enum logic [1:0] {
        RESP_LIMIT_FOREVER = 2'h0,
        RESP_UNSUPPORTED = 2'h1,
        RESP_LIMIT_DELAY = 2'h2,
        RESP_SHUTDOWN = 2'h3
    } resp_t;
    // channel states, gray along off-run-limit-shut-retry
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_RUN = 3'h1,
        ST_LIMIT = 3'h3,
        ST_SHUT = 3'h2,
        ST_RETRY = 3'h6
    } state_t;
    // timing
    localparam int CLK_FREQ_KHZ = 250000;
    localparam int DELAY_UNIT_MS = 16;
    localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_MS * CLK_FREQ_KHZ;
    localparam int RETRY_UNIT_MS = 1;
    localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * CLK_FREQ_KHZ;
    localparam int SYNC_STAGES = 2;
endpackage

// ### ocf_timer_if.sv
`timescale 1ns/1ps
interface ocf_timer_if;
    logic load;
    logic unit_sel;
    logic [7:0] units;
    logic done;
    logic busy;
    modport ctrl (output load, output unit_sel, output units, input done, input busy);
    modport timer (input load, input unit_sel, input units, output done, output busy);
endinterface

// ### ocf_sync.sv
`timescale 1ns/1ps
module ocf_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;
    // two flops per bit; only the second stage is visible outside
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ### ocf_interval_timer.sv
`timescale 1ns/1ps
module ocf_interval_timer
    import ocf_pkg::*;
#(
    parameter int unsigned DELAY_TICK = DELAY_UNIT_CYCLES,
    parameter int unsigned RETRY_TICK = RETRY_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    ocf_timer_if.timer tif
);
    logic [31:0] pre_q;
    logic [7:0] units_q;
    logic busy_q;
    logic done_q;
    logic sel_q;
    // the unit select only stands in the load cycle, so it is kept for the later ticks
    wire use_retry = tif.load ? tif.unit_sel : sel_q;
    wire [31:0] tick_len = use_retry ? 32'(RETRY_TICK - 1) : 32'(DELAY_TICK - 1);
    wire tick = busy_q && (pre_q == 32'h0);
    wire [7:0] units_dec = units_q - 8'h01;

    assign tif.done = done_q;
    assign tif.busy = busy_q;

    // a load restarts the count, so a stale run never leaks a done
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 32'h0;
            units_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            sel_q <= 1'b0;
        end else if (tif.load) begin
            sel_q <= tif.unit_sel;
            pre_q <= tick_len;
            units_q <= tif.units;
            busy_q <= (tif.units != 8'h00);
            done_q <= (tif.units == 8'h00);
        end else if (tick) begin
            pre_q <= tick_len;
            units_q <= units_dec;
            busy_q <= (units_dec != 8'h00);
            done_q <= (units_dec == 8'h00);
        end else begin
            pre_q <= busy_q ? pre_q - 32'h1 : pre_q;
            done_q <= 1'b0;
        end
    end

    AST_ZERO_UNITS: assert property (@(posedge clk) disable iff (!rst_n)
        tif.load && tif.units == 8'h00 |=> done_q && !busy_q)
        else $error("zero delay did not expire at once");
endmodule

// ### overcurrent_fault_response.sv
`timescale 1ns/1ps
// Operation
// - an overcurrent fault sets the byte, word and current-status overcurrent flags.
// - every overcurrent fault raises the alert line unless that source is masked.
// - flags clear only by clear-faults, an off-then-on cycle, or bias loss.
// - response 00 keeps running forever with current held at the limit.
// - response 10 holds current limit for the delay in bits 2:0.
// - still limiting when that delay ends, act per the retry field.
// - response 11 shuts the channel at once, then acts per the retry field.
// - retry codes 000-110 never restart; output off until run pin or operation cycles.
// - retry 111 restarts forever until commanded off, bias lost, other fault.
// - restart attempts are spaced by the restart interval setting.
// - delay field counts 16 ms units, used only by the delayed shutdown path.
// - internal overtemperature response byte at 0xD6, read only, value 0xC0.
// - overcurrent response byte at 0x47, read/write, reset value 0x00.
module overcurrent_fault_response
    import ocf_pkg::*;
#(
    parameter int unsigned DELAY_TICK = DELAY_UNIT_CYCLES,
    parameter int unsigned RETRY_TICK = RETRY_UNIT_CYCLES
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic OC_DETECT,
    input wire logic RUN_CONTROL_PIN,
    input wire logic OPERATION_ON,
    input wire logic OTHER_FAULT,
    input wire logic ALERT_MASK,
    input wire logic [7:0] RESTART_INTERVAL_SETTING,
    input wire logic CMD_VALID,
    input wire logic CMD_WRITE,
    input wire logic [7:0] CMD_CODE,
    input wire logic [7:0] CMD_WDATA,
    output logic [7:0] CMD_RDATA,
    output logic CMD_DONE,
    output logic CH_ENABLE,
    output logic CURRENT_LIMIT,
    output logic STATUS_BYTE_IOUT_OC,
    output logic STATUS_WORD_IOUT,
    output logic STATUS_IOUT_OC_FAULT,
    output logic CML_FAULT,
    output logic ALERT_O,
    output logic ALERT_OE
);
    state_t state_q, state_d;
    logic [7:0] oc_resp_q;
    logic oc_flag_q, alert_q, cml_q, hold_off_q, on_q;
    logic ch_en_q, limit_q, rdone_q, alert_o_q;
    logic [7:0] rdata_q;
    logic [1:0] pins_s;
    logic t_load, t_sel;
    logic [7:0] t_units;

    ocf_timer_if tif ();

    // both pins are asynchronous to CLK
    ocf_sync #(.W(2)) u_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .d({RUN_CONTROL_PIN, OC_DETECT}),
        .q(pins_s)
    );

    ocf_interval_timer #(.DELAY_TICK(DELAY_TICK), .RETRY_TICK(RETRY_TICK)) u_timer (
        .clk(CLK),
        .rst_n(RST_N),
        .tif(tif.timer)
    );

    // field decode of the stored response byte
    wire oc_s = pins_s[0];
    wire run_s = pins_s[1];
    wire [1:0] resp = oc_resp_q[RESP_MSB:RESP_LSB];
    wire [2:0] retry = oc_resp_q[RETRY_MSB:RETRY_LSB];
    wire [7:0] delay_units = {5'h00, oc_resp_q[DELAY_MSB:DELAY_LSB]};
    wire resp_forever = (resp == RESP_LIMIT_FOREVER);
    wire resp_delay = (resp == RESP_LIMIT_DELAY);
    wire resp_shut = (resp == RESP_SHUTDOWN);

    // command decode
    wire cmd_wr = CMD_VALID && CMD_WRITE;
    wire cmd_rd = CMD_VALID && !CMD_WRITE;
    wire wr_oc = cmd_wr && (CMD_CODE == CMD_OC_RESPONSE);
    wire wr_ro = cmd_wr && (CMD_CODE == CMD_INT_OT_RESPONSE);
    wire clr_cmd = cmd_wr && (CMD_CODE == CMD_CLEAR_FAULTS);
    wire bad_resp = wr_oc && (CMD_WDATA[RESP_MSB:RESP_LSB] == RESP_UNSUPPORTED);
    wire good_wr = wr_oc && !bad_resp;
    // a write to the read-only byte is also a communication fault
    wire cml_set = bad_resp || wr_ro;

    // the channel is commanded on by pin and operation together
    wire on_cmd = run_s && OPERATION_ON;
    wire on_rise = on_cmd && !on_q;
    wire flag_clr = clr_cmd || on_rise;
    wire oc_event = oc_s && (state_q == ST_RUN) && on_cmd && !OTHER_FAULT;
    wire run_d = (state_d == ST_RUN) || (state_d == ST_LIMIT);

    // read data mux
    wire [7:0] rd_mux = (CMD_CODE == CMD_OC_RESPONSE) ? oc_resp_q :
                        (CMD_CODE == CMD_INT_OT_RESPONSE) ? INT_OT_RESPONSE_VALUE :
                        RDATA_UNMAPPED;

    // timer requests come straight from the state decision
    assign tif.load = t_load;
    assign tif.unit_sel = t_sel;
    assign tif.units = t_units;

    // next state; off command and foreign faults override everything
    always_comb begin
        state_d = state_q;
        t_load = 1'b0;
        t_sel = 1'b0;
        t_units = delay_units;
        if (!on_cmd) begin
            state_d = ST_OFF;
        end else if (OTHER_FAULT) begin
            state_d = ST_OFF;
        end else begin
            case (state_q)
                ST_OFF: begin
                    if (!hold_off_q) begin
                        state_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (oc_s && resp_forever) begin
                        state_d = ST_LIMIT;
                    end else if (oc_s && resp_delay) begin
                        state_d = ST_LIMIT;
                        t_load = 1'b1;
                    end else if (oc_s && resp_shut) begin
                        state_d = ST_SHUT;
                    end
                end
                ST_LIMIT: begin
                    if (!oc_s) begin
                        state_d = ST_RUN;
                    end else if (resp_shut) begin
                        state_d = ST_SHUT;
                    end else if (resp_delay && tif.done) begin
                        state_d = ST_SHUT;
                    end
                end
                ST_SHUT: begin
                    // retry codes below 111 stay latched off until the channel is commanded off
                    if (retry == RETRY_FOREVER) begin
                        state_d = ST_RETRY;
                        t_load = 1'b1;
                        t_sel = 1'b1;
                        t_units = RESTART_INTERVAL_SETTING;
                    end else begin
                        state_d = ST_SHUT;
                    end
                end
                ST_RETRY: begin
                    if (tif.done) begin
                        state_d = ST_RUN;
                    end
                end
                default: begin
                    state_d = ST_OFF;
                end
            endcase
        end
    end

    // state and channel drive, registered so the outputs are glitch free
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_OFF;
            ch_en_q <= 1'b0;
            limit_q <= 1'b0;
            on_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ch_en_q <= run_d;
            limit_q <= (state_d == ST_LIMIT);
            on_q <= on_cmd;
        end
    end

    // a foreign fault keeps the channel down until it is commanded off
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            hold_off_q <= 1'b0;
        end else begin
            hold_off_q <= on_cmd && (hold_off_q || OTHER_FAULT);
        end
    end

    // sticky flags; a set in the clearing cycle wins
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            oc_flag_q <= 1'b0;
            alert_q <= 1'b0;
            cml_q <= 1'b0;
        end else begin
            oc_flag_q <= oc_event || (oc_flag_q && !flag_clr);
            alert_q <= (oc_event && !ALERT_MASK) || (alert_q && !flag_clr);
            cml_q <= cml_set || (cml_q && !clr_cmd);
        end
    end

    // response byte; the unsupported code never lands in it
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            oc_resp_q <= OC_RESPONSE_RESET;
        end else if (good_wr) begin
            oc_resp_q <= CMD_WDATA;
        end
    end

    // command answer one cycle after the request
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
            rdone_q <= 1'b0;
            alert_o_q <= 1'b0;
        end else begin
            rdata_q <= cmd_rd ? rd_mux : rdata_q;
            rdone_q <= CMD_VALID;
            alert_o_q <= 1'b0;
        end
    end

    // alert is open drain: only ever pulled low
    assign ALERT_O = alert_o_q;
    assign ALERT_OE = alert_q;
    assign CMD_RDATA = rdata_q;
    assign CMD_DONE = rdone_q;
    assign CH_ENABLE = ch_en_q;
    assign CURRENT_LIMIT = limit_q;
    assign STATUS_BYTE_IOUT_OC = oc_flag_q;
    assign STATUS_WORD_IOUT = oc_flag_q;
    assign STATUS_IOUT_OC_FAULT = oc_flag_q;
    assign CML_FAULT = cml_q;

    wire stay_on = on_cmd && !OTHER_FAULT;

    AST_FLAG_SET: assert property (@(posedge CLK) disable iff (!RST_N)
        oc_event |=> STATUS_IOUT_OC_FAULT && STATUS_WORD_IOUT && STATUS_BYTE_IOUT_OC)
        else $error("fault flags not set by overcurrent");
    AST_ALERT: assert property (@(posedge CLK) disable iff (!RST_N)
        oc_event && !ALERT_MASK |=> ALERT_OE && !ALERT_O)
        else $error("alert not pulled on unmasked fault");
    AST_FLAG_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
        STATUS_IOUT_OC_FAULT && !flag_clr |=> STATUS_IOUT_OC_FAULT)
        else $error("fault flag dropped without a clearing event");
    AST_LIMIT_FOREVER: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == ST_LIMIT && resp_forever && oc_s && stay_on
        |=> state_q == ST_LIMIT && CURRENT_LIMIT && CH_ENABLE)
        else $error("indefinite limiting left early");
    AST_DELAY_LIMIT: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == ST_RUN && oc_s && resp_delay && stay_on
        |-> tif.load && tif.units == delay_units ##1 CURRENT_LIMIT && CH_ENABLE)
        else $error("delayed limiting not entered");
    AST_EXPIRE_SHUT: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == ST_LIMIT && resp_delay && tif.done && oc_s && stay_on
        |=> state_q == ST_SHUT && !CH_ENABLE)
        else $error("no shutdown at end of limit delay");
    AST_IMMEDIATE_SHUT: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == ST_RUN && oc_s && resp_shut && stay_on |=> !CH_ENABLE)
        else $error("immediate shutdown response did not disable");
    AST_LATCHED_OFF: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == ST_SHUT && retry != RETRY_FOREVER && on_cmd |=> !CH_ENABLE)
        else $error("latched-off channel restarted");
    AST_RETRY_ARM: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == ST_SHUT && retry == RETRY_FOREVER && stay_on
        |=> state_q == ST_RETRY ##0 tif.busy || tif.done)
        else $error("continuous retry not armed");
    AST_RETRY_WAIT: assert property (@(posedge CLK) disable iff (!RST_N)
        state_q == ST_RETRY && !tif.done |=> !CH_ENABLE)
        else $error("restart before interval elapsed");
    AST_RO_BYTE: assert property (@(posedge CLK) disable iff (!RST_N)
        cmd_rd && CMD_CODE == CMD_INT_OT_RESPONSE |=> CMD_DONE && CMD_RDATA == 8'hC0)
        else $error("internal overtemperature byte read wrong");
    AST_RESP_WRITE: assert property (@(posedge CLK) disable iff (!RST_N)
        good_wr |=> oc_resp_q == $past(CMD_WDATA))
        else $error("response byte write lost");
    AST_BAD_RESP: assert property (@(posedge CLK) disable iff (!RST_N)
        bad_resp |=> CML_FAULT && oc_resp_q == $past(oc_resp_q))
        else $error("unsupported response accepted");

    // exits and sticky bits that the scenarios only reach now and then
    AST_FLAG_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
        clr_cmd && !oc_event |=> !STATUS_IOUT_OC_FAULT)
        else $error("clear command left the fault flag set");
    AST_ALERT_MASKED: assert property (@(posedge CLK) disable iff (!RST_N)
        ALERT_MASK && !ALERT_OE |=> !ALERT_OE)
        else $error("masked alert source pulled the line");
    AST_OFF_CMD: assert property (@(posedge CLK) disable iff (!RST_N)
        !on_cmd |=> !CH_ENABLE && !CURRENT_LIMIT)
        else $error("channel kept running while commanded off");
    AST_OTHER_OFF: assert property (@(posedge CLK) disable iff (!RST_N)
        OTHER_FAULT || hold_off_q |=> !CH_ENABLE)
        else $error("channel restarted after a foreign fault");
    AST_CML_WRITE: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_ro |=> CML_FAULT && CMD_DONE)
        else $error("write to read-only byte not flagged");
    AST_CML_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
        CML_FAULT && !clr_cmd |=> CML_FAULT)
        else $error("communication fault dropped without clear");
endmodule

// ### ocf_host_model.sv
`timescale 1ns/1ps
module ocf_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [7:0] cmd_wdata,
    input wire logic [7:0] cmd_rdata,
    input wire logic cmd_done
);
    int timeouts = 0;
    // idle command lines before the first transfer
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 8'h00;
    end
    // one byte transfer: strobe held for one taking edge, answer taken with done
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        int i;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        cmd_wdata = wdata;
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_write = ~wr; // released lines must not keep showing the old value
        cmd_code = ~code;
        cmd_wdata = ~wdata;
        // done already stands here, half a cycle after the taking edge
        for (i = 0; i < 4; i++) begin
            if (cmd_done === 1'b1) break;
            @(negedge clk);
        end
        if (i == 4) timeouts++;
        rdata = cmd_rdata;
    endtask
endmodule

// ### overcurrent_fault_response_test.sv
`timescale 1ns/1ps
module overcurrent_fault_response_test;
    import ocf_pkg::*;
    localparam int unsigned DT = 10;
    localparam int unsigned RT = 8;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic OC_DETECT = 1'b0;
    logic RUN = 1'b0;
    logic OP_ON = 1'b0;
    logic ALERT_MASK = 1'b1;
    logic OTHER_FAULT = 1'b0;
    logic [7:0] RETRY_SET = 8'h03;
    logic CMD_VALID;
    logic CMD_WRITE;
    logic [7:0] CMD_CODE;
    logic [7:0] CMD_WDATA;
    logic [7:0] CMD_RDATA;
    logic CMD_DONE;
    logic CH_ENABLE;
    logic CURRENT_LIMIT;
    logic SB;
    logic SW;
    logic SI;
    logic CML_FAULT;
    logic ALERT_O;
    logic ALERT_OE;
    int n_mismatch = 0;
    int checks_done = 0;

    always #2 CLK = ~CLK;

    overcurrent_fault_response #(.DELAY_TICK(DT), .RETRY_TICK(RT))
        overcurrent_fault_response_inst (
        .CLK(CLK), .RST_N(RST_N), .OC_DETECT(OC_DETECT), .RUN_CONTROL_PIN(RUN),
        .OPERATION_ON(OP_ON), .OTHER_FAULT(OTHER_FAULT), .ALERT_MASK(ALERT_MASK),
        .RESTART_INTERVAL_SETTING(RETRY_SET), .CMD_VALID(CMD_VALID), .CMD_WRITE(CMD_WRITE),
        .CMD_CODE(CMD_CODE), .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA),
        .CMD_DONE(CMD_DONE), .CH_ENABLE(CH_ENABLE), .CURRENT_LIMIT(CURRENT_LIMIT),
        .STATUS_BYTE_IOUT_OC(SB), .STATUS_WORD_IOUT(SW), .STATUS_IOUT_OC_FAULT(SI),
        .CML_FAULT(CML_FAULT), .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE));

    ocf_host_model ocf_host_model_inst (
        .clk(CLK), .cmd_valid(CMD_VALID), .cmd_write(CMD_WRITE), .cmd_code(CMD_CODE),
        .cmd_wdata(CMD_WDATA), .cmd_rdata(CMD_RDATA), .cmd_done(CMD_DONE));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge CLK);
    endtask

    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        logic [7:0] r;
        ocf_host_model_inst.xfer(1'b1, code, data, r);
    endtask

    task automatic rd(input logic [7:0] code, output logic [7:0] data);
        ocf_host_model_inst.xfer(1'b0, code, 8'h00, data);
    endtask

    // channel outputs plus all three copies of the shared status flag
    task automatic st(input logic en, input logic lim, input logic flg);
        chk({6'h00, CH_ENABLE, CURRENT_LIMIT}, {6'h00, en, lim});
        chk({5'h00, SB, SW, SI}, {5'h00, flg, flg, flg});
    endtask

    task automatic end_sim;
        n_mismatch += ocf_host_model_inst.timeouts;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // reset values, read-only byte, unmapped code and the refused response code
    task automatic t_regs;
        logic [7:0] r;
        st(1'b0, 1'b0, 1'b0);
        rd(CMD_OC_RESPONSE, r);
        chk(r, 8'h00);
        rd(CMD_INT_OT_RESPONSE, r);
        chk(r, 8'hC0);
        chk({7'h00, CML_FAULT}, 8'h00);
        wr(CMD_INT_OT_RESPONSE, 8'h00);
        chk({7'h00, CML_FAULT}, 8'h01);
        rd(CMD_INT_OT_RESPONSE, r);
        chk(r, 8'hC0);
        wr(CMD_CLEAR_FAULTS, 8'h00);
        chk({7'h00, CML_FAULT}, 8'h00);
        rd(8'h55, r);
        chk(r, 8'h00);
        wr(CMD_OC_RESPONSE, 8'h40);
        chk({7'h00, CML_FAULT}, 8'h01);
        rd(CMD_OC_RESPONSE, r);
        chk(r, 8'h00);
        $display("test regs done");
    endtask

    // limit forever with the alert masked, then flags cleared by command
    task automatic t_limit;
        RUN = 1'b1;
        OP_ON = 1'b1;
        cyc(6);
        st(1'b1, 1'b0, 1'b0);
        OC_DETECT = 1'b1;
        cyc(60);
        st(1'b1, 1'b1, 1'b1);
        chk({7'h00, ALERT_OE}, 8'h00);
        OC_DETECT = 1'b0;
        cyc(6);
        st(1'b1, 1'b0, 1'b1);
        wr(CMD_CLEAR_FAULTS, 8'h00);
        cyc(2);
        st(1'b1, 1'b0, 1'b0);
        ALERT_MASK = 1'b0;
        $display("test limit done");
    endtask

    // immediate shutdown, latched off until the run pin cycles
    task automatic t_latch;
        wr(CMD_OC_RESPONSE, 8'hC0);
        OC_DETECT = 1'b1;
        cyc(5);
        st(1'b0, 1'b0, 1'b1);
        chk({6'h00, ALERT_OE, ALERT_O}, 8'h02);
        OC_DETECT = 1'b0;
        cyc(60);
        st(1'b0, 1'b0, 1'b1);
        RUN = 1'b0;
        cyc(6);
        RUN = 1'b1;
        cyc(6);
        st(1'b1, 1'b0, 1'b0);
        chk({6'h00, ALERT_OE, ALERT_O}, 8'h00);
        $display("test latch done");
    endtask

    // endless restart, spaced by 3 retry units of RT cycles
    task automatic t_retry;
        wr(CMD_OC_RESPONSE, 8'hF8);
        OC_DETECT = 1'b1;
        cyc(5);
        OC_DETECT = 1'b0;
        cyc(10);
        st(1'b0, 1'b0, 1'b1);
        cyc(12);
        chk({7'h00, CH_ENABLE}, 8'h00);
        cyc(4);
        chk({7'h00, CH_ENABLE}, 8'h01);
        OC_DETECT = 1'b1;
        cyc(5);
        chk({7'h00, CH_ENABLE}, 8'h00);
        OC_DETECT = 1'b0;
        cyc(40);
        chk({7'h00, CH_ENABLE}, 8'h01);
        $display("test retry done");
    endtask

    // limit for 2 delay units, then shut down while still limiting
    task automatic t_delay;
        logic [7:0] r;
        wr(CMD_OC_RESPONSE, 8'h82);
        rd(CMD_OC_RESPONSE, r);
        chk(r, 8'h82);
        wr(CMD_CLEAR_FAULTS, 8'h00);
        st(1'b1, 1'b0, 1'b0);
        OC_DETECT = 1'b1;
        cyc(12);
        st(1'b1, 1'b1, 1'b1);
        cyc(10);
        st(1'b1, 1'b1, 1'b1);
        cyc(4);
        st(1'b0, 1'b0, 1'b1);
        OC_DETECT = 1'b0;
        cyc(30);
        chk({7'h00, CH_ENABLE}, 8'h00);
        $display("test delay done");
    endtask

    // bias loss while latched off: all back to reset, then the channel comes up again
    task automatic t_bias;
        logic [7:0] r;
        RST_N = 1'b0;
        cyc(2);
        st(1'b0, 1'b0, 1'b0);
        RST_N = 1'b1;
        cyc(1);
        st(1'b0, 1'b0, 1'b0);
        rd(CMD_OC_RESPONSE, r);
        chk(r, 8'h00);
        cyc(6);
        st(1'b1, 1'b0, 1'b0);
        $display("test bias done");
    endtask

    // one-unit restart, retry stopped by an off command, foreign fault without restart
    task automatic t_other;
        wr(CMD_OC_RESPONSE, 8'hF8);
        RETRY_SET = 8'h01;
        OC_DETECT = 1'b1;
        cyc(5);
        OC_DETECT = 1'b0;
        cyc(6);
        chk({7'h00, CH_ENABLE}, 8'h00);
        cyc(4);
        chk({7'h00, CH_ENABLE}, 8'h01);
        OC_DETECT = 1'b1;
        cyc(5);
        OC_DETECT = 1'b0;
        OP_ON = 1'b0;
        cyc(30);
        chk({7'h00, CH_ENABLE}, 8'h00);
        OP_ON = 1'b1;
        cyc(4);
        st(1'b1, 1'b0, 1'b0);
        OTHER_FAULT = 1'b1;
        cyc(3);
        chk({7'h00, CH_ENABLE}, 8'h00);
        OTHER_FAULT = 1'b0;
        cyc(30);
        chk({7'h00, CH_ENABLE}, 8'h00);
        OP_ON = 1'b0;
        cyc(3);
        OP_ON = 1'b1;
        cyc(4);
        chk({7'h00, CH_ENABLE}, 8'h01);
        $display("test other done");
    endtask

    // a hang is cut short here
    initial begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        end_sim();
    end

    initial begin
        cyc(5);
        RST_N = 1'b1;
        cyc(1);
        t_regs();
        t_limit();
        t_latch();
        t_retry();
        t_delay();
        t_bias();
        t_other();
        end_sim();
    end
endmodule
